// [hdl/tkc_pkg.sv]
// constants shared by the timekeeper control block
package tkc_pkg;
	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CORE_PERIOD_PS = 4000;
	localparam int STALL_TIME_NS = 100000;
	localparam int STALL_CYCLES = (STALL_TIME_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;

	// ************************************************************
	// register map, byte addresses
	// ************************************************************
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_TIME_VALUE = 8'h04;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

	// ************************************************************
	// control field positions
	// ************************************************************
	localparam int CTRL_OE_BIT = 0;
	localparam int CTRL_HALF_BIT = 1;
	localparam int CTRL_SYNC_BIT = 2;
	localparam int CTRL_WREN_BIT = 3;
	localparam int CTRL_RUN_BIT = 6;
	localparam int CTRL_OUTSEL_LSB = 7;
	localparam int CTRL_CLKSEL_LSB = 9;
	localparam int CTRL_ON_BIT = 15;
	localparam int TIME_SEC_LSB = 8;
	localparam int TIME_SEC_MSB = 14;

	// ************************************************************
	// field encodings
	// ************************************************************
	localparam logic [1:0] CLKSEL_INTERNAL = 2'h0;
	localparam logic [1:0] CLKSEL_SECONDARY = 2'h1;
	localparam logic [1:0] OUTSEL_ALARM = 2'h0;
	localparam logic [1:0] OUTSEL_SECONDS = 2'h1;
	localparam logic [1:0] OUTSEL_TKCLK = 2'h2;

	// ************************************************************
	// prescaler and seconds
	// ************************************************************
	localparam logic [14:0] TICKS_LAST = 15'h7fff;
	localparam logic [14:0] TICKS_HALF = 15'h4000;
	localparam logic [14:0] SYNC_LEAD = 15'h0020;
	localparam logic [6:0] SEC_LAST = 7'h3b;

	// bus slave states
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} tkc_bus_t;
endpackage

// [hdl/tkc_prescaler.sv]
// divider from timekeeping clock edges to a one-second tick
`timescale 1ns/100ps
module tkc_prescaler
	import tkc_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// control
	input wire logic i_tick,
	input wire logic i_clear,
	// status
	output logic [14:0] o_count,
	output logic o_half,
	output logic o_second
);

	// ************************************************************
	// divider
	// ************************************************************
	// count timekeeping edges, clear wins over a tick
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_count <= 15'h0000;
		end else if (i_clear) begin
			o_count <= 15'h0000;
		end else if (i_tick) begin
			o_count <= o_count + 15'h0001;
		end
	end

	// one-cycle pulse at the wrap to a new second
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_second <= 1'b0;
		end else begin
			o_second <= i_tick && !i_clear && (o_count == TICKS_LAST);
		end
	end

	// second half of the second
	assign o_half = (o_count >= TICKS_HALF);
endmodule

// [hdl/tkc_control.sv]
// timekeeper control register, clock select and output pin logic
`timescale 1ns/100ps
module tkc_control
	import tkc_pkg::*;
#(
	parameter int STALL_LIMIT = STALL_CYCLES
)
(
	// clock and power-on reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// avalon-mm slave
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// oscillators and system
	input wire logic i_internal_low_power_osc,
	input wire logic i_secondary_oscillator,
	input wire logic i_unlock_active,
	input wire logic i_alarm_event,
	// timekeeper pin and events
	output logic o_timekeeper_pin,
	output logic o_timekeeper_pin_oe,
	output logic o_second_tick,
	output logic o_seconds_write
);

	// ************************************************************
	// declarations
	// ************************************************************
	tkc_bus_t bus_state;
	logic output_enable;
	logic value_write_enable;
	logic module_on;
	logic [1:0] output_source_select;
	logic [1:0] clock_source_select;
	logic clock_running_status;
	logic [6:0] seconds;
	logic sel_level;
	logic sel_prev;
	logic tk_edge;
	logic tk_tick;
	logic [14:0] presc_count;
	logic half_second_status;
	logic second_pulse;
	logic read_sync_status;
	logic [$clog2(STALL_LIMIT + 1)-1:0] stall_count;
	logic alarm_pending;
	logic alarm_pulse;
	logic pin_source;
	logic bus_take;
	logic ctrl_wr;
	logic time_wr;
	logic [31:0] next_readdata;

	// ************************************************************
	// avalon-mm slave
	// ************************************************************
	// a request is taken at the edge where waitrequest is low
	assign bus_take = (bus_state == BUS_ACK) && (i_read || i_write);
	assign ctrl_wr = bus_take && i_write && (i_address == ADDR_CONTROL);
	assign time_wr = bus_take && i_write && (i_address == ADDR_TIME_VALUE) && i_byteenable[1];

	// one wait cycle then one ready cycle per request
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bus_state <= BUS_IDLE;
			o_waitrequest <= 1'b1;
		end else begin
			unique case (bus_state)
				BUS_IDLE: begin
					if (i_read || i_write) begin
						bus_state <= BUS_ACK;
						o_waitrequest <= 1'b0;
					end
				end
				BUS_ACK: begin
					bus_state <= BUS_IDLE;
					o_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		if (i_address == ADDR_CONTROL) begin
			next_readdata[CTRL_OE_BIT] = output_enable;
			next_readdata[CTRL_HALF_BIT] = half_second_status;
			next_readdata[CTRL_SYNC_BIT] = read_sync_status;
			next_readdata[CTRL_WREN_BIT] = value_write_enable;
			next_readdata[CTRL_RUN_BIT] = clock_running_status;
			next_readdata[CTRL_OUTSEL_LSB +: 2] = output_source_select;
			next_readdata[CTRL_CLKSEL_LSB +: 2] = clock_source_select;
			next_readdata[CTRL_ON_BIT] = module_on;
		end else if (i_address == ADDR_TIME_VALUE) begin
			next_readdata[TIME_SEC_MSB:TIME_SEC_LSB] = seconds;
		end
	end

	// read data loaded as waitrequest drops; bits 5:4 never set
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_readdata <= 32'h0000_0000;
		end else if (bus_state == BUS_IDLE && i_read) begin
			o_readdata <= next_readdata;
		end
	end

	// ************************************************************
	// control register
	// ************************************************************
	// only the power-on reset clears these fields
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			output_enable <= CONTROL_RESET[CTRL_OE_BIT];
			value_write_enable <= CONTROL_RESET[CTRL_WREN_BIT];
			module_on <= CONTROL_RESET[CTRL_ON_BIT];
			output_source_select <= CONTROL_RESET[CTRL_OUTSEL_LSB +: 2];
			clock_source_select <= CONTROL_RESET[CTRL_CLKSEL_LSB +: 2];
		end else if (ctrl_wr) begin
			if (i_byteenable[0]) begin
				output_enable <= i_writedata[CTRL_OE_BIT];
				// set needs the unlock sequence, clear is always allowed
				if (!i_writedata[CTRL_WREN_BIT] || i_unlock_active) begin
					value_write_enable <= i_writedata[CTRL_WREN_BIT];
				end
				output_source_select[0] <= i_writedata[CTRL_OUTSEL_LSB];
			end
			if (i_byteenable[1]) begin
				output_source_select[1] <= i_writedata[CTRL_OUTSEL_LSB + 1];
				clock_source_select <= i_writedata[CTRL_CLKSEL_LSB +: 2];
				if (value_write_enable) begin
					module_on <= i_writedata[CTRL_ON_BIT];
				end
			end
		end
	end

	// ************************************************************
	// time value and seconds count
	// ************************************************************
	// seconds load needs write enable, else counts on the tick
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			seconds <= 7'h00;
		end else if (time_wr && value_write_enable) begin
			seconds <= i_writedata[TIME_SEC_MSB:TIME_SEC_LSB];
		end else if (second_pulse) begin
			seconds <= (seconds >= SEC_LAST) ? 7'h00 : seconds + 7'h01;
		end
	end

	// seconds-write pulse for the calendar counters
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_seconds_write <= 1'b0;
			o_second_tick <= 1'b0;
		end else begin
			o_seconds_write <= time_wr && value_write_enable;
			o_second_tick <= second_pulse;
		end
	end

	// ************************************************************
	// clock source and prescaler
	// ************************************************************
	// source mux, reserved codes give no clock
	always_comb begin
		sel_level = 1'b0;
		if (clock_source_select == CLKSEL_INTERNAL) begin
			sel_level = i_internal_low_power_osc;
		end else if (clock_source_select == CLKSEL_SECONDARY) begin
			sel_level = i_secondary_oscillator;
		end
	end

	// rising edge of the selected timekeeping clock
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_prev <= 1'b0;
		end else begin
			sel_prev <= sel_level;
		end
	end

	assign tk_edge = sel_level && !sel_prev;
	assign tk_tick = tk_edge && module_on;

	// prescaler restarts on a seconds write
	tkc_prescaler u_prescaler (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_tick(tk_tick),
		.i_clear(o_seconds_write),
		.o_count(presc_count),
		.o_half(half_second_status),
		.o_second(second_pulse)
	);

	// busy near the wrap and during the ripple cycle
	assign read_sync_status = module_on &&
		((presc_count >= TICKS_LAST - SYNC_LEAD) || second_pulse || o_second_tick);

	// ************************************************************
	// clock running detection
	// ************************************************************
	// core cycles since the last timekeeping edge, saturating
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stall_count <= '0;
			clock_running_status <= 1'b0;
		end else begin
			if (tk_edge) begin
				stall_count <= '0;
			end else if (stall_count < STALL_LIMIT[$bits(stall_count)-1:0]) begin
				stall_count <= stall_count + 1'b1;
			end
			clock_running_status <= module_on &&
				(stall_count < STALL_LIMIT[$bits(stall_count)-1:0]);
		end
	end

	// ************************************************************
	// alarm pulse and output pin
	// ************************************************************
	// pending alarm waits for a timekeeping edge; a new event wins
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			alarm_pending <= 1'b0;
			alarm_pulse <= 1'b0;
		end else begin
			if (i_alarm_event) begin
				alarm_pending <= 1'b1;
			end else if (tk_edge) begin
				alarm_pending <= 1'b0;
			end
			if (tk_edge) begin
				alarm_pulse <= alarm_pending;
			end
		end
	end

	// pin source mux, reserved code drives low
	always_comb begin
		pin_source = 1'b0;
		unique case (output_source_select)
			OUTSEL_ALARM: pin_source = alarm_pulse;
			OUTSEL_SECONDS: pin_source = half_second_status;
			OUTSEL_TKCLK: pin_source = sel_level;
			default: pin_source = 1'b0;
		endcase
	end

	// enable gates both the level and the driver
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_timekeeper_pin <= 1'b0;
			o_timekeeper_pin_oe <= 1'b0;
		end else begin
			o_timekeeper_pin <= output_enable && pin_source;
			o_timekeeper_pin_oe <= output_enable;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_req_waiting;
		(bus_state == BUS_IDLE) && (i_read || i_write);
	endsequence

	sequence s_ready_then_wait;
		!o_waitrequest ##1 o_waitrequest;
	endsequence

	property p_bus_answer;
		s_req_waiting |=> s_ready_then_wait;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one cycle");

	property p_clksel_edge;
		(clock_source_select == CLKSEL_SECONDARY) && module_on && i_secondary_oscillator
			&& !sel_prev |=> (presc_count != $past(presc_count)) || $past(o_seconds_write);
	endproperty
	a_clksel_edge: assert property (p_clksel_edge) else $error("secondary edge not counted");

	property p_tkclk_out;
		output_enable && (output_source_select == OUTSEL_TKCLK) |=>
			o_timekeeper_pin == $past(sel_level);
	endproperty
	a_tkclk_out: assert property (p_tkclk_out) else $error("clock not on pin");

	property p_alarm_out;
		output_enable && (output_source_select == OUTSEL_ALARM) |=>
			o_timekeeper_pin == $past(alarm_pulse);
	endproperty
	a_alarm_out: assert property (p_alarm_out) else $error("alarm pulse not on pin");

	property p_oe_gate;
		!output_enable |=> !o_timekeeper_pin && !o_timekeeper_pin_oe;
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("pin active while disabled");

	property p_time_locked;
		bus_take && i_write && (i_address == ADDR_TIME_VALUE) && !value_write_enable
			|=> !o_seconds_write;
	endproperty
	a_time_locked: assert property (p_time_locked) else $error("locked time write took");

	property p_wren_unlock;
		ctrl_wr && i_byteenable[0] && !i_unlock_active && !value_write_enable
			|=> !value_write_enable;
	endproperty
	a_wren_unlock: assert property (p_wren_unlock) else $error("write enable set locked");

	property p_on_locked;
		ctrl_wr && !value_write_enable |=> $stable(module_on);
	endproperty
	a_on_locked: assert property (p_on_locked) else $error("on bit changed while locked");

	property p_half_clear;
		time_wr && value_write_enable |=> ##1 !half_second_status;
	endproperty
	a_half_clear: assert property (p_half_clear) else $error("half second not cleared");

	property p_sync_at_wrap;
		second_pulse |-> $past(read_sync_status) && read_sync_status;
	endproperty
	a_sync_at_wrap: assert property (p_sync_at_wrap) else $error("sync low at rollover");

	property p_unimpl_zero;
		!o_waitrequest |-> o_readdata[5:4] == 2'b00;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("bits 5:4 not zero");
endmodule

// [tb/tkc_osc_model.sv]
// oscillator partner model feeding both timekeeping clock sources
`timescale 1ns/100ps
module tkc_osc_model
(
	// clock
	input wire logic i_core_clk,
	// control
	input wire logic i_run,
	// oscillator levels
	output logic o_secondary_oscillator,
	output logic o_internal_low_power_osc
);
	// ************************************************************
	// oscillator levels
	// ************************************************************
	logic [1:0] int_div = 2'h0;

	initial begin
		o_secondary_oscillator = 1'b0;
		o_internal_low_power_osc = 1'b0;
	end

	// secondary toggles each core cycle, holds its level while stopped
	always @(posedge i_core_clk) begin
		if (i_run) begin
			o_secondary_oscillator <= ~o_secondary_oscillator;
		end
	end

	// internal toggles every third core cycle, never stops
	always @(posedge i_core_clk) begin
		int_div <= (int_div == 2'h2) ? 2'h0 : int_div + 2'h1;
		if (int_div == 2'h2) begin
			o_internal_low_power_osc <= ~o_internal_low_power_osc;
		end
	end
endmodule

// [tb/tkc_control_bench.sv]
// self-checking bench for the timekeeper control block
`timescale 1ns/100ps
module tkc_control_bench
	import tkc_pkg::*;
;
	// ************************************************************
	// signals
	// ************************************************************
	localparam int STALL_SIM = 64;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [3:0] byteenable = 4'h0;
	logic unlock_active = 1'b0;
	logic alarm_event = 1'b0;
	logic osc_run = 1'b1;
	logic [31:0] readdata;
	logic waitrequest;
	logic pin;
	logic pin_oe;
	logic sec_osc;
	logic int_osc;
	logic [31:0] rd;
	int errors = 0;
	int check_count = 0;
	logic second_tick;
	logic seconds_write;
	int tick_count = 0;
	int swr_count = 0;

	tkc_control #(.STALL_LIMIT(STALL_SIM)) DUT (
		.i_core_clk(core_clk),
		.i_resetn(resetn),
		.i_address(address),
		.i_read(read),
		.i_write(write),
		.i_writedata(writedata),
		.i_byteenable(byteenable),
		.o_readdata(readdata),
		.o_waitrequest(waitrequest),
		.i_internal_low_power_osc(int_osc),
		.i_secondary_oscillator(sec_osc),
		.i_unlock_active(unlock_active),
		.i_alarm_event(alarm_event),
		.o_timekeeper_pin(pin),
		.o_timekeeper_pin_oe(pin_oe),
		.o_second_tick(second_tick),
		.o_seconds_write(seconds_write)
	);

	tkc_osc_model PARTNER (
		.i_core_clk(core_clk),
		.i_run(osc_run),
		.o_secondary_oscillator(sec_osc),
		.o_internal_low_power_osc(int_osc)
	);

	// 250 MHz core clock
	initial begin
		forever #2 core_clk = ~core_clk;
	end

	// count one-cycle event pulses, sampled mid-cycle
	always @(negedge core_clk) begin
		if (second_tick === 1'b1) begin
			tick_count++;
		end
		if (seconds_write === 1'b1) begin
			swr_count++;
		end
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one avalon transfer, held until waitrequest seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		byteenable <= 4'hf;
		read <= ~wr;
		write <= wr;
		n = 0;
		@(negedge core_clk);
		while (waitrequest !== 1'b0 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 20) begin
			errors++;
			close_out();
		end
		rd = readdata;
		@(posedge core_clk);
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check_word(rd, exp);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// pin must show the selected level one core cycle late
	task automatic pin_follow(input logic use_sec, input logic en, input logic oe);
		logic prev;
		// driver enable register follows the write one cycle late
		@(negedge core_clk);
		@(negedge core_clk);
		check_bit(pin_oe, oe);
		prev = use_sec ? sec_osc : int_osc;
		repeat (8) begin
			@(negedge core_clk);
			check_bit(pin, en & prev);
			prev = use_sec ? sec_osc : int_osc;
		end
	endtask

	// one alarm event, count core cycles with the pin high
	task automatic alarm_count(input int exp);
		int n;
		n = 0;
		@(posedge core_clk);
		alarm_event <= 1'b1;
		@(posedge core_clk);
		alarm_event <= 1'b0;
		repeat (24) begin
			@(negedge core_clk);
			if (pin === 1'b1) n++;
		end
		check_word(32'(n), 32'(exp));
	endtask

	// expected control word, module on and write enable set
	function automatic logic [31:0] ctl(input logic [1:0] osel, input logic oe,
		input logic half = 1'b0, input logic sync = 1'b0, input logic run = 1'b1,
		input logic [1:0] csel = CLKSEL_SECONDARY);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[CTRL_ON_BIT] = 1'b1;
		v[CTRL_WREN_BIT] = 1'b1;
		v[CTRL_OUTSEL_LSB +: 2] = osel;
		v[CTRL_CLKSEL_LSB +: 2] = csel;
		v[CTRL_OE_BIT] = oe;
		v[CTRL_HALF_BIT] = half;
		v[CTRL_SYNC_BIT] = sync;
		v[CTRL_RUN_BIT] = run;
		return v;
	endfunction

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		rdchk(ADDR_CONTROL, CONTROL_RESET);
		rdchk(8'h08, 32'h0000_0000);
		wr(ADDR_CONTROL, 32'h0000_8008);
		rdchk(ADDR_CONTROL, 32'h0000_0000);
		@(posedge core_clk);
		unlock_active <= 1'b1;
		wr(ADDR_CONTROL, 32'h0000_8000);
		rdchk(ADDR_CONTROL, 32'h0000_0000);
		wr(ADDR_CONTROL, 32'h0000_0008);
		rdchk(ADDR_CONTROL, 32'h0000_0008);
		@(posedge core_clk);
		unlock_active <= 1'b0;
		// read-only and unimplemented bits written as ones
		wr(ADDR_CONTROL, ctl(OUTSEL_TKCLK, 1'b0) | 32'h0000_0076);
		wr(ADDR_TIME_VALUE, 32'h0000_1500);
		wait_cyc(8);
		rdchk(ADDR_CONTROL, ctl(OUTSEL_TKCLK, 1'b0));
		pin_follow(1'b1, 1'b0, 1'b0);
		wr(ADDR_CONTROL, ctl(OUTSEL_TKCLK, 1'b1));
		pin_follow(1'b1, 1'b1, 1'b1);
		wr(ADDR_CONTROL, ctl(2'h3, 1'b1));
		pin_follow(1'b1, 1'b0, 1'b1);
		wr(ADDR_CONTROL, ctl(OUTSEL_TKCLK, 1'b1, 1'b0, 1'b0, 1'b1, CLKSEL_INTERNAL));
		pin_follow(1'b0, 1'b1, 1'b1);
		wr(ADDR_CONTROL, ctl(OUTSEL_ALARM, 1'b1));
		alarm_count(2);
		wr(ADDR_CONTROL, ctl(OUTSEL_ALARM, 1'b0));
		alarm_count(0);
		// stopped secondary oscillator
		@(posedge core_clk);
		osc_run <= 1'b0;
		wait_cyc(2 * STALL_SIM);
		rdchk(ADDR_CONTROL, ctl(OUTSEL_ALARM, 1'b0, 1'b0, 1'b0, 1'b0));
		@(posedge core_clk);
		osc_run <= 1'b1;
		wait_cyc(8);
		rdchk(ADDR_CONTROL, ctl(OUTSEL_ALARM, 1'b0));
		// one prescaler run, in osc edges of two core cycles each
		wr(ADDR_CONTROL, ctl(OUTSEL_SECONDS, 1'b1));
		wr(ADDR_TIME_VALUE, 32'h0000_1500);
		wait_cyc(2 * 32'h3f00);
		rdchk(ADDR_CONTROL, ctl(OUTSEL_SECONDS, 1'b1));
		@(negedge core_clk);
		check_bit(pin, 1'b0);
		wait_cyc(2 * 32'h0200);
		rdchk(ADDR_CONTROL, ctl(OUTSEL_SECONDS, 1'b1, 1'b1));
		@(negedge core_clk);
		check_bit(pin, 1'b1);
		wait_cyc(2 * (32'h7fe8 - 32'h4100));
		rdchk(ADDR_CONTROL, ctl(OUTSEL_SECONDS, 1'b1, 1'b1, 1'b1));
		rdchk(ADDR_TIME_VALUE, 32'h0000_1500);
		rdchk(ADDR_TIME_VALUE, 32'h0000_1500);
		// let the prescaler wrap once into the next second
		wait_cyc(64);
		rdchk(ADDR_TIME_VALUE, 32'h0000_1600);
		rdchk(ADDR_CONTROL, ctl(OUTSEL_SECONDS, 1'b1));
		wr(ADDR_TIME_VALUE, 32'h0000_2a00);
		wait_cyc(4);
		rdchk(ADDR_CONTROL, ctl(OUTSEL_SECONDS, 1'b1));
		rdchk(ADDR_TIME_VALUE, 32'h0000_2a00);
		// locked value registers and on bit
		wr(ADDR_CONTROL, ctl(OUTSEL_SECONDS, 1'b1) & 32'hffff_fff7);
		wr(ADDR_CONTROL, ctl(OUTSEL_SECONDS, 1'b1) & 32'hffff_7ff7);
		wr(ADDR_TIME_VALUE, 32'h0000_1100);
		rdchk(ADDR_TIME_VALUE, 32'h0000_2a00);
		rdchk(ADDR_CONTROL, ctl(OUTSEL_SECONDS, 1'b1) & 32'hffff_fff7);
		check_word(32'(tick_count), 32'h0000_0001);
		check_word(32'(swr_count), 32'h0000_0003);
		close_out();
	end
endmodule
